//--- core/rcd_pkg.sv
/*
  Shared constants and types of the 16-bit RISC core: instruction fields,
  opcodes, status bits, fixed addresses and the sequencer states.
  Assumes a 16-bit word-addressed-by-byte memory map with vectors at the top.
*/
`default_nettype none
package rcd_pkg;
  localparam int XLEN = 16;
  localparam logic [15:0] RST_VEC_ADDR = 16'hFFFE;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [15:0] VEC_BASE = 16'hFFC0;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] BYTE_MASK = 16'h00FF;
  localparam logic [15:0] WORD_MASK = 16'hFFFF;
  // Status bit positions
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_GIE = 3;
  localparam int SR_CPUOFF = 4;
  localparam int SR_V = 8;
  localparam int SR_LPM_LO = 4;
  localparam logic [15:0] SR_LPM_DEEP = 16'h00F0;
  localparam logic [15:0] SR_IRQ_CLR = 16'h00B8;
  // Dedicated register indices
  localparam logic [3:0] IDX_PC = 4'h0;
  localparam logic [3:0] IDX_SP = 4'h1;
  localparam logic [3:0] IDX_SR = 4'h2;
  localparam logic [3:0] IDX_CG = 4'h3;
  localparam int GPR_FIRST = 4;
  localparam int GPR_LAST = 15;
  // Operand modes
  localparam logic [1:0] AM_REG = 2'h0;
  localparam logic [1:0] AM_IDX = 2'h1;
  localparam logic [1:0] AM_IND = 2'h2;
  localparam logic [1:0] AM_INC = 2'h3;
  // Dual-operand opcodes
  localparam logic [3:0] OP_MOV = 4'h4;
  localparam logic [3:0] OP_ADD = 4'h5;
  localparam logic [3:0] OP_ADDC = 4'h6;
  localparam logic [3:0] OP_SUBC = 4'h7;
  localparam logic [3:0] OP_SUB = 4'h8;
  localparam logic [3:0] OP_CMP = 4'h9;
  localparam logic [3:0] OP_DADD = 4'hA;
  localparam logic [3:0] OP_BIT = 4'hB;
  localparam logic [3:0] OP_BIC = 4'hC;
  localparam logic [3:0] OP_BIS = 4'hD;
  localparam logic [3:0] OP_XOR = 4'hE;
  localparam logic [3:0] OP_AND = 4'hF;
  // Single-operand opcodes
  localparam logic [5:0] F2_PREFIX = 6'h04;
  localparam logic [2:0] F2_RRC = 3'h0;
  localparam logic [2:0] F2_SWPB = 3'h1;
  localparam logic [2:0] F2_RRA = 3'h2;
  localparam logic [2:0] F2_SXT = 3'h3;
  localparam logic [2:0] F2_PUSH = 3'h4;
  localparam logic [2:0] F2_CALL = 3'h5;
  localparam logic [2:0] F2_RETI = 3'h6;
  // Jump conditions
  localparam logic [2:0] JUMP_PREFIX = 3'h1;
  localparam logic [2:0] JC_NE = 3'h0;
  localparam logic [2:0] JC_EQ = 3'h1;
  localparam logic [2:0] JC_NC = 3'h2;
  localparam logic [2:0] JC_C = 3'h3;
  localparam logic [2:0] JC_N = 3'h4;
  localparam logic [2:0] JC_GE = 3'h5;
  localparam logic [2:0] JC_L = 3'h6;
  typedef enum logic [12:0] {
    ST_RV = 13'h0001,
    ST_DEC = 13'h0002,
    ST_SEXT = 13'h0004,
    ST_SRD = 13'h0008,
    ST_DEXT = 13'h0010,
    ST_DRD = 13'h0020,
    ST_WR = 13'h0040,
    ST_RT1 = 13'h0080,
    ST_RT2 = 13'h0100,
    ST_IRQ1 = 13'h0200,
    ST_IRQ2 = 13'h0400,
    ST_VEC = 13'h0800,
    ST_SLEEP = 13'h1000
  } rcd_state_e;
endpackage
`default_nettype wire

//--- core/rcd_rf_if.sv
/*
  Port bundle between the core sequencer and its general register file.
  Assumes one write port and two combinational read ports.
*/
`default_nettype none
interface rcd_rf_if;
  logic [3:0] rs_idx;
  logic [3:0] rd_idx;
  logic [15:0] rs_val;
  logic [15:0] rd_val;
  logic we;
  logic [3:0] w_idx;
  logic [15:0] w_data;
  modport core (output rs_idx, output rd_idx, output we, output w_idx, output w_data,
                input rs_val, input rd_val);
  modport file (input rs_idx, input rd_idx, input we, input w_idx, input w_data,
                output rs_val, output rd_val);
endinterface
`default_nettype wire

//--- core/rcd_regfile.sv
/*
  General registers 4..15 of the core; 0..3 live in the sequencer.
  Assumes the caller never reads indices below 4 through this file.
*/
`default_nettype none
module rcd_regfile (
  input wire logic clk,
  input wire logic rst_n,
  rcd_rf_if.file rf
);
  logic [15:0] gpr [rcd_pkg::GPR_FIRST:rcd_pkg::GPR_LAST];
  genvar g;
  generate
    for (g = rcd_pkg::GPR_FIRST; g <= rcd_pkg::GPR_LAST; g++) begin : g_reg
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          gpr[g] <= 16'h0000;
        end else if (rf.we && rf.w_idx == 4'(g)) begin
          gpr[g] <= rf.w_data;
        end
      end
    end
  endgenerate
  // Read is combinational so a register-to-register step fits one clock
  assign rf.rs_val = (rf.rs_idx >= 4'h4) ? gpr[rf.rs_idx] : 16'h0000;
  assign rf.rd_val = (rf.rd_idx >= 4'h4) ? gpr[rf.rd_idx] : 16'h0000;
endmodule // rcd_regfile
`default_nettype wire

//--- core/rcd_core.sv
/*
  16-bit RISC core: decoder, sequencer, ALU and system bus master.
  Assumes memory answers a read combinationally in the cycle MEM_RD is high,
  and that interrupt requests come from logic on REF_CLK.
*/
// Functional notes
// - Datapath, registers and arithmetic are 16 bits
// - Seven source modes, four destination modes
// - Non-flow operations are register plus operand modes
// - Sixteen registers visible to instructions
// - Register-to-register instruction takes one clock
// - Registers 0-3: PC, SP, status, constants
// - Registers 4-15 are plain general purpose
// - Peripherals reached over shared address/data/control bus
// - Decode all three instruction formats
// - Word or byte width per encoding
// - Dual-operand result written to destination, except CMP and BIT
// - Call pushes PC, loads PC from operand
// - Not-equal jump taken only when Z clear
// - Vector word loaded into PC on interrupt
// - Erased reset vector enters deepest sleep
// - Interrupt wakes; return restores sleep mode
`default_nettype none
module rcd_core (
  input wire logic REF_CLK,
  input wire logic RST_N,
  output logic [15:0] MEM_ADDR,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic MEM_BYTE,
  output logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  input wire logic IRQ_REQ,
  input wire logic [4:0] IRQ_NUM,
  output logic IRQ_ACK,
  output logic [3:0] SLEEP_MODE
);
  rcd_pkg::rcd_state_e state, next_state;
  logic [15:0] pc, sp, sr, ir, src_val, dst_addr;
  logic [15:0] next_pc, next_sp, next_sr, next_ir, next_src, next_dst;
  logic [15:0] next_addr, next_wdata;
  logic next_rd, next_wr, next_byte, next_ack;
  logic go_fetch, src_done, do_exec;

  rcd_rf_if rf ();
  rcd_regfile u_rf (.clk(REF_CLK), .rst_n(RST_N), .rf(rf.file));

  // Field decode; in ST_DEC the instruction is still on the bus
  wire st_dec = (state == rcd_pkg::ST_DEC);
  wire st_srd = (state == rcd_pkg::ST_SRD);
  wire st_drd = (state == rcd_pkg::ST_DRD);
  wire [15:0] inst = st_dec ? MEM_RDATA : ir;
  wire is_jmp = (inst[15:13] == rcd_pkg::JUMP_PREFIX);
  wire is_f2 = (inst[15:10] == rcd_pkg::F2_PREFIX);
  wire is_f1 = (inst[15:14] != 2'h0);
  wire [3:0] op = inst[15:12];
  wire [2:0] f2op = inst[9:7];
  wire [3:0] rs = is_f2 ? inst[3:0] : inst[11:8];
  wire [3:0] rdx = inst[3:0];
  wire ad = inst[7];
  wire bw = inst[6] & ~is_jmp;
  wire [1:0] as_m = inst[5:4];
  wire [15:0] msk = bw ? rcd_pkg::BYTE_MASK : rcd_pkg::WORD_MASK;

  // Constant source and dedicated register reads
  wire cg = (rs == rcd_pkg::IDX_CG) || (rs == rcd_pkg::IDX_SR && as_m[1]);
  wire [15:0] cg_val = (rs == rcd_pkg::IDX_SR) ? (as_m[0] ? 16'h0008 : 16'h0004) :
                       (as_m == 2'h3) ? 16'hFFFF : {14'h0000, as_m};
  wire [15:0] pc_cur = st_dec ? pc + rcd_pkg::WORD_STEP : pc;
  assign rf.rs_idx = rs;
  assign rf.rd_idx = rdx;
  wire [15:0] rs_raw = (rs == rcd_pkg::IDX_PC) ? pc_cur : (rs == rcd_pkg::IDX_SP) ? sp :
                       (rs == rcd_pkg::IDX_SR) ? sr : rf.rs_val;
  wire [15:0] rd_raw = (rdx == rcd_pkg::IDX_PC) ? pc_cur : (rdx == rcd_pkg::IDX_SP) ? sp :
                       (rdx == rcd_pkg::IDX_SR) ? sr : (rdx == rcd_pkg::IDX_CG) ? 16'h0000 :
                       rf.rd_val;
  wire src_direct = (as_m == rcd_pkg::AM_REG) || cg;
  wire [15:0] step = (bw && rs > rcd_pkg::IDX_SP) ? rcd_pkg::BYTE_STEP : rcd_pkg::WORD_STEP;
  wire [15:0] sbase = (rs == rcd_pkg::IDX_SR) ? 16'h0000 : rs_raw;
  wire [15:0] dbase = (rdx == rcd_pkg::IDX_SR) ? 16'h0000 : rd_raw;
  wire [15:0] rdsel = !bw ? MEM_RDATA : MEM_ADDR[0] ? {8'h00, MEM_RDATA[15:8]} :
                      {8'h00, MEM_RDATA[7:0]};
  wire [15:0] cur_src = st_dec ? ((cg ? cg_val : rs_raw) & msk) : st_srd ? rdsel : src_val;
  wire [15:0] cur_dst = is_f2 ? cur_src : st_drd ? rdsel : (rd_raw & msk);

  // Jump target and condition
  wire [15:0] jtarget = pc + rcd_pkg::WORD_STEP + {{5{inst[9]}}, inst[9:0], 1'b0};
  wire nv = sr[rcd_pkg::SR_N] ^ sr[rcd_pkg::SR_V];
  wire jtake = (inst[12:10] == rcd_pkg::JC_NE) ? ~sr[rcd_pkg::SR_Z] :
               (inst[12:10] == rcd_pkg::JC_EQ) ? sr[rcd_pkg::SR_Z] :
               (inst[12:10] == rcd_pkg::JC_NC) ? ~sr[rcd_pkg::SR_C] :
               (inst[12:10] == rcd_pkg::JC_C) ? sr[rcd_pkg::SR_C] :
               (inst[12:10] == rcd_pkg::JC_N) ? sr[rcd_pkg::SR_N] :
               (inst[12:10] == rcd_pkg::JC_GE) ? ~nv :
               (inst[12:10] == rcd_pkg::JC_L) ? nv : 1'b1;
  wire irq_take = IRQ_REQ && sr[rcd_pkg::SR_GIE];

  // Adder shared by the add, subtract and compare group
  wire is_sub = (op == rcd_pkg::OP_SUB) || (op == rcd_pkg::OP_SUBC) || (op == rcd_pkg::OP_CMP);
  wire [15:0] sx = (is_sub ? ~cur_src : cur_src) & msk;
  wire [15:0] dm = cur_dst & msk;
  wire cin = (op == rcd_pkg::OP_ADD) ? 1'b0 : (op == rcd_pkg::OP_SUB || op == rcd_pkg::OP_CMP) ?
             1'b1 : sr[rcd_pkg::SR_C];
  wire [16:0] sum = {1'b0, dm} + {1'b0, sx} + {16'h0000, cin};
  wire msb_d = bw ? dm[7] : dm[15];
  wire msb_s = bw ? sx[7] : sx[15];
  wire msb_r = bw ? sum[7] : sum[15];

  // Decimal add, one nibble per stage
  logic [4:0] dc;
  logic [15:0] dres;
  assign dc[0] = sr[rcd_pkg::SR_C];
  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_bcd
      wire [4:0] t = {1'b0, dm[4*n+3:4*n]} + {1'b0, cur_src[4*n+3:4*n]} + {4'h0, dc[n]};
      wire adj = (t > 5'h09);
      wire [4:0] u = t + (adj ? 5'h06 : 5'h00);
      assign dres[4*n+3:4*n] = u[3:0];
      assign dc[n+1] = adj;
    end
  endgenerate

  logic [15:0] alu_res;
  logic alu_c, alu_v, alu_wr, alu_fl, c_notz;
  always_comb begin
    alu_res = cur_src;
    alu_c = sr[rcd_pkg::SR_C];
    alu_v = 1'b0;
    alu_wr = 1'b1;
    alu_fl = 1'b1;
    c_notz = 1'b0;
    if (is_f2) begin
      case (f2op)
        rcd_pkg::F2_RRC: begin
          alu_res = bw ? {8'h00, sr[rcd_pkg::SR_C], dm[7:1]} : {sr[rcd_pkg::SR_C], dm[15:1]};
          alu_c = dm[0];
        end
        rcd_pkg::F2_SWPB: begin
          alu_res = {dm[7:0], dm[15:8]};
          alu_fl = 1'b0;
        end
        rcd_pkg::F2_RRA: begin
          alu_res = bw ? {8'h00, dm[7], dm[7:1]} : {dm[15], dm[15:1]};
          alu_c = dm[0];
        end
        rcd_pkg::F2_SXT: begin
          alu_res = {{8{dm[7]}}, dm[7:0]};
          c_notz = 1'b1;
        end
        default: begin
          alu_wr = 1'b0;
          alu_fl = 1'b0;
        end
      endcase
    end else begin
      case (op)
        rcd_pkg::OP_MOV: alu_fl = 1'b0;
        rcd_pkg::OP_ADD, rcd_pkg::OP_ADDC, rcd_pkg::OP_SUB, rcd_pkg::OP_SUBC,
        rcd_pkg::OP_CMP: begin
          alu_res = sum[15:0] & msk;
          alu_c = bw ? sum[8] : sum[16];
          alu_v = (msb_d == msb_s) && (msb_r != msb_d);
          alu_wr = (op != rcd_pkg::OP_CMP);
        end
        rcd_pkg::OP_DADD: begin
          alu_res = dres & msk;
          alu_c = bw ? dc[2] : dc[4];
        end
        rcd_pkg::OP_BIT, rcd_pkg::OP_AND: begin
          alu_res = dm & cur_src;
          c_notz = 1'b1;
          alu_wr = (op == rcd_pkg::OP_AND);
        end
        rcd_pkg::OP_BIC: begin
          alu_res = dm & ~cur_src & msk;
          alu_fl = 1'b0;
        end
        rcd_pkg::OP_BIS: begin
          alu_res = dm | cur_src;
          alu_fl = 1'b0;
        end
        default: begin
          alu_res = (dm ^ cur_src) & msk;
          c_notz = 1'b1;
          alu_v = msb_d && (bw ? cur_src[7] : cur_src[15]);
        end
      endcase
    end
  end
  wire alu_z = ((alu_res & msk) == 16'h0000);
  wire alu_n = bw ? alu_res[7] : alu_res[15];

  // Register write port: index 0..2 land in the dedicated registers
  logic gp_we;
  logic [3:0] gp_idx;
  logic [15:0] gp_wd;
  assign rf.we = gp_we && (gp_idx > rcd_pkg::IDX_CG);
  assign rf.w_idx = gp_idx;
  assign rf.w_data = gp_wd;

  always_comb begin
    next_state = state;
    next_pc = pc;
    next_sp = sp;
    next_sr = sr;
    next_ir = ir;
    next_src = src_val;
    next_dst = dst_addr;
    next_addr = MEM_ADDR;
    next_rd = 1'b0;
    next_wr = 1'b0;
    next_byte = 1'b0;
    next_wdata = MEM_WDATA;
    next_ack = 1'b0;
    go_fetch = 1'b0;
    src_done = 1'b0;
    do_exec = 1'b0;
    gp_we = 1'b0;
    gp_idx = rdx;
    gp_wd = alu_res;
    case (state)
      rcd_pkg::ST_RV: begin
        if (MEM_RDATA == rcd_pkg::ERASED_WORD) begin
          next_sr = rcd_pkg::SR_LPM_DEEP;
        end else begin
          next_pc = MEM_RDATA;
        end
        go_fetch = 1'b1;
      end
      rcd_pkg::ST_DEC, rcd_pkg::ST_SLEEP: begin
        if (irq_take) begin
          // Interrupted fetch is discarded and re-fetched on return
          next_sp = sp - rcd_pkg::WORD_STEP;
          next_addr = sp - rcd_pkg::WORD_STEP;
          next_wr = 1'b1;
          next_wdata = pc;
          next_state = rcd_pkg::ST_IRQ1;
        end else if (st_dec) begin
          next_ir = MEM_RDATA;
          next_pc = pc + rcd_pkg::WORD_STEP;
          if (is_jmp) begin
            if (jtake) next_pc = jtarget;
            go_fetch = 1'b1;
          end else if (is_f2 && f2op == rcd_pkg::F2_RETI) begin
            next_addr = sp;
            next_rd = 1'b1;
            next_state = rcd_pkg::ST_RT1;
          end else if (is_f1 || is_f2) begin
            if (src_direct) begin
              src_done = 1'b1;
            end else if (as_m == rcd_pkg::AM_IDX) begin
              next_addr = pc_cur;
              next_rd = 1'b1;
              next_state = rcd_pkg::ST_SEXT;
            end else begin
              next_addr = rs_raw;
              next_rd = 1'b1;
              // Byte operand reads carry the strobe, so odd lanes stay legal on the bus
              next_byte = bw;
              next_state = rcd_pkg::ST_SRD;
              if (as_m == rcd_pkg::AM_INC) begin
                gp_we = 1'b1;
                gp_idx = rs;
                gp_wd = rs_raw + step;
              end
            end
          end else begin
            go_fetch = 1'b1;
          end
        end
      end
      rcd_pkg::ST_SEXT: begin
        next_pc = pc + rcd_pkg::WORD_STEP;
        next_addr = sbase + MEM_RDATA;
        next_rd = 1'b1;
        next_byte = bw;
        next_state = rcd_pkg::ST_SRD;
      end
      rcd_pkg::ST_SRD: src_done = 1'b1;
      rcd_pkg::ST_DEXT: begin
        next_pc = pc + rcd_pkg::WORD_STEP;
        next_dst = dbase + MEM_RDATA;
        next_addr = dbase + MEM_RDATA;
        next_rd = 1'b1;
        next_byte = bw;
        next_state = rcd_pkg::ST_DRD;
      end
      rcd_pkg::ST_DRD: begin
        do_exec = 1'b1;
        if (alu_wr) begin
          next_addr = dst_addr;
          next_wr = 1'b1;
          next_byte = bw;
          next_wdata = bw ? {alu_res[7:0], alu_res[7:0]} : alu_res;
          next_state = rcd_pkg::ST_WR;
        end else begin
          go_fetch = 1'b1;
        end
      end
      rcd_pkg::ST_RT1: begin
        next_sr = MEM_RDATA;
        next_sp = sp + rcd_pkg::WORD_STEP;
        next_addr = sp + rcd_pkg::WORD_STEP;
        next_rd = 1'b1;
        next_state = rcd_pkg::ST_RT2;
      end
      rcd_pkg::ST_RT2: begin
        next_pc = MEM_RDATA;
        next_sp = sp + rcd_pkg::WORD_STEP;
        go_fetch = 1'b1;
      end
      rcd_pkg::ST_IRQ1: begin
        next_sp = sp - rcd_pkg::WORD_STEP;
        next_addr = sp - rcd_pkg::WORD_STEP;
        next_wr = 1'b1;
        next_wdata = sr;
        next_sr = sr & ~rcd_pkg::SR_IRQ_CLR;
        next_state = rcd_pkg::ST_IRQ2;
      end
      rcd_pkg::ST_IRQ2: begin
        next_addr = rcd_pkg::VEC_BASE + {10'h000, IRQ_NUM, 1'b0};
        next_rd = 1'b1;
        next_ack = 1'b1;
        next_state = rcd_pkg::ST_VEC;
      end
      rcd_pkg::ST_VEC: begin
        next_pc = MEM_RDATA;
        go_fetch = 1'b1;
      end
      rcd_pkg::ST_WR: go_fetch = 1'b1;
      default: begin
        next_addr = rcd_pkg::RST_VEC_ADDR;
        next_rd = 1'b1;
        next_state = rcd_pkg::ST_RV;
      end
    endcase
    if (src_done) begin
      next_src = cur_src;
      if (is_f2 && (f2op == rcd_pkg::F2_PUSH || f2op == rcd_pkg::F2_CALL)) begin
        next_sp = sp - rcd_pkg::WORD_STEP;
        next_addr = sp - rcd_pkg::WORD_STEP;
        next_wr = 1'b1;
        next_state = rcd_pkg::ST_WR;
        if (f2op == rcd_pkg::F2_CALL) begin
          next_wdata = pc_cur;
          next_pc = cur_src;
        end else begin
          next_byte = bw;
          next_wdata = bw ? {cur_src[7:0], cur_src[7:0]} : cur_src;
        end
      end else if (is_f2) begin
        do_exec = 1'b1;
        if (src_direct) begin
          gp_we = alu_wr && !cg;
          gp_idx = rs;
          go_fetch = 1'b1;
        end else begin
          next_wr = alu_wr;
          next_byte = bw;
          next_wdata = bw ? {alu_res[7:0], alu_res[7:0]} : alu_res;
          next_state = rcd_pkg::ST_WR;
        end
      end else if (!ad) begin
        do_exec = 1'b1;
        gp_we = alu_wr;
        go_fetch = 1'b1;
      end else begin
        next_pc = pc_cur;
        next_addr = pc_cur;
        next_rd = 1'b1;
        next_state = rcd_pkg::ST_DEXT;
      end
    end
    if (do_exec && alu_fl) begin
      next_sr[rcd_pkg::SR_C] = c_notz ? ~alu_z : alu_c;
      next_sr[rcd_pkg::SR_Z] = alu_z;
      next_sr[rcd_pkg::SR_N] = alu_n;
      next_sr[rcd_pkg::SR_V] = alu_v;
    end
    if (gp_we) begin
      if (gp_idx == rcd_pkg::IDX_PC) next_pc = gp_wd;
      if (gp_idx == rcd_pkg::IDX_SP) next_sp = gp_wd;
      if (gp_idx == rcd_pkg::IDX_SR) next_sr = gp_wd;
    end
    if (go_fetch) begin
      if (next_sr[rcd_pkg::SR_CPUOFF]) begin
        next_state = rcd_pkg::ST_SLEEP;
      end else begin
        next_addr = next_pc;
        next_rd = 1'b1;
        next_state = rcd_pkg::ST_DEC;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state <= rcd_pkg::ST_RV;
      MEM_ADDR <= rcd_pkg::RST_VEC_ADDR;
      MEM_RD <= 1'b1;
      MEM_WR <= 1'b0;
      MEM_BYTE <= 1'b0;
      MEM_WDATA <= 16'h0000;
      IRQ_ACK <= 1'b0;
      {pc, sp, sr, ir, src_val, dst_addr} <= {6{16'h0000}};
    end else begin
      state <= next_state;
      MEM_ADDR <= next_addr;
      MEM_RD <= next_rd;
      MEM_WR <= next_wr;
      MEM_BYTE <= next_byte;
      MEM_WDATA <= next_wdata;
      IRQ_ACK <= next_ack;
      {pc, sp, sr, ir, src_val, dst_addr} <=
        {next_pc, next_sp, next_sr, next_ir, next_src, next_dst};
    end
  end
  // Low-power mode bits are a direct view of the status register
  assign SLEEP_MODE = sr[rcd_pkg::SR_LPM_LO+3:rcd_pkg::SR_LPM_LO];
endmodule // rcd_core
`default_nettype wire

//--- sim/rcd_core_properties.sv
/*
  Port checker for the core: reset vector, sleep entry, bus shape, interrupt entry.
  Assumes binding onto rcd_core and a zero-wait memory on the same clock.
*/
`default_nettype none
module rcd_core_properties (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic MEM_BYTE,
  input wire logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  input wire logic IRQ_REQ,
  input wire logic [4:0] IRQ_NUM,
  input wire logic IRQ_ACK,
  input wire logic [3:0] SLEEP_MODE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dcb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  property p_rst_vec;
    $rose(RST_N) |-> MEM_RD && !MEM_WR && MEM_ADDR == rcd_pkg::RST_VEC_ADDR;
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector not read");
  property p_erased;
    $rose(RST_N) && MEM_RDATA == rcd_pkg::ERASED_WORD |=>
      SLEEP_MODE == 4'hF && !MEM_RD && !MEM_WR;
  endproperty
  a_erased: assert property (p_erased) else $error("erased vector did not sleep");
  property p_rd_wr;
    !(MEM_RD && MEM_WR);
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("read and write together");
  property p_ack_pulse;
    IRQ_ACK |=> !IRQ_ACK;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_addr;
    IRQ_ACK |-> MEM_RD && MEM_ADDR == rcd_pkg::VEC_BASE + {10'h000, $past(IRQ_NUM), 1'b0};
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("wrong vector address");
  property p_ack_jump;
    IRQ_ACK |=> MEM_RD && MEM_ADDR == $past(MEM_RDATA);
  endproperty
  a_ack_jump: assert property (p_ack_jump) else $error("handler not fetched");
  property p_ack_saves;
    IRQ_ACK |-> $past(MEM_WR) && $past(MEM_WR, 2);
  endproperty
  a_ack_saves: assert property (p_ack_saves) else $error("state not stacked");
  property p_byte_lanes;
    MEM_WR && MEM_BYTE |-> MEM_WDATA[15:8] == MEM_WDATA[7:0];
  endproperty
  a_byte_lanes: assert property (p_byte_lanes) else $error("byte lanes differ");
  property p_word_align;
    (MEM_RD || MEM_WR) && !MEM_BYTE |-> !MEM_ADDR[0];
  endproperty
  a_word_align: assert property (p_word_align) else $error("odd word address");
endmodule // rcd_core_properties
bind rcd_core rcd_core_properties prop_u (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_BYTE(MEM_BYTE),
  .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .IRQ_REQ(IRQ_REQ), .IRQ_NUM(IRQ_NUM),
  .IRQ_ACK(IRQ_ACK), .SLEEP_MODE(SLEEP_MODE));
`default_nettype wire

//--- sim/rcd_mem_model.sv
/*
  Zero-wait memory and peripheral space on the core's system bus.
  Assumes one access per cycle; the bench preloads mem directly.
*/
`default_nettype none
module rcd_mem_model (
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic byte_en,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:32767];
  logic [15:0] last = 16'h0000;
  // Idle bus shows the inverse of the last word, so stale data never matches
  assign rdata = rd ? mem[addr[15:1]] : ~last;
  always @(posedge clk) begin
    if (rd) last <= mem[addr[15:1]];
    if (wr && !byte_en) mem[addr[15:1]] <= wdata;
    if (wr && byte_en && addr[0]) mem[addr[15:1]][15:8] <= wdata[15:8];
    if (wr && byte_en && !addr[0]) mem[addr[15:1]][7:0] <= wdata[7:0];
  end
endmodule // rcd_mem_model
`default_nettype wire

//--- sim/tb_risc16_cpu_core_decode.sv
/*
  Self-checking bench: ALU rows, conditional jump, call, interrupt, erased vector.
  Assumes rcd_core, rcd_mem_model and the bound checker are compiled first.
*/
`default_nettype none
module tb_risc16_cpu_core_decode;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [3:0] op; logic bw; logic [15:0] a; logic [15:0] b; logic [15:0] e;}
    rcd_row_s;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic IRQ_REQ = 1'b0;
  logic [4:0] IRQ_NUM = 5'h00;
  logic [15:0] MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic MEM_RD, MEM_WR, MEM_BYTE, IRQ_ACK;
  logic [3:0] SLEEP_MODE;
  int n_fail = 0;
  int n_tests = 0;
  logic [15:0] pg [$];
  rcd_row_s rows [12] = '{'{4'h4, 1'b0, 16'h1234, 16'h5678, 16'h1234},
    '{4'h5, 1'b0, 16'hFFFF, 16'h0001, 16'h0000}, '{4'h8, 1'b0, 16'h0001, 16'h0000, 16'hFFFF},
    '{4'hF, 1'b0, 16'hF0F0, 16'h3C3C, 16'h3030}, '{4'hE, 1'b0, 16'hF0F0, 16'h3C3C, 16'hCCCC},
    '{4'hD, 1'b0, 16'hF0F0, 16'h0F0F, 16'hFFFF}, '{4'hC, 1'b0, 16'hF0F0, 16'hFFFF, 16'h0F0F},
    '{4'h5, 1'b1, 16'h12FF, 16'h3402, 16'h0001}, '{4'hE, 1'b1, 16'h1234, 16'hFF00, 16'h0034},
    '{4'hA, 1'b0, 16'h0019, 16'h0023, 16'h0042}, '{4'h7, 1'b0, 16'h0001, 16'h0005, 16'h0003},
    '{4'hB, 1'b0, 16'h00FF, 16'h1234, 16'h1234}};
  always #5 REF_CLK = ~REF_CLK;
  rcd_core dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
    .MEM_WR(MEM_WR), .MEM_BYTE(MEM_BYTE), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
    .IRQ_REQ(IRQ_REQ), .IRQ_NUM(IRQ_NUM), .IRQ_ACK(IRQ_ACK), .SLEEP_MODE(SLEEP_MODE));
  rcd_mem_model mem_u (.clk(REF_CLK), .addr(MEM_ADDR), .rd(MEM_RD), .wr(MEM_WR),
    .byte_en(MEM_BYTE), .wdata(MEM_WDATA), .rdata(MEM_RDATA));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Each test reboots, so reset release is exercised in mid-run too
  task automatic boot(input logic [15:0] vec);
    RST_N = 1'b0;
    for (int i = 0; i < 32768; i++) mem_u.mem[i] = 16'h0000;
    mem_u.mem[16'h7FFF] = vec;
    mem_u.mem[16'h7FE5] = 16'h2000;
    mem_u.mem[16'h1000] = 16'h1300;
    foreach (pg[i]) mem_u.mem[16'h0800 + i] = pg[i];
    repeat (16) @(negedge REF_CLK);
    chk("reset addr", 16'hFFFE, MEM_ADDR);
    RST_N = 1'b1;
  endtask
  // Bounded wait for a read or write at one address
  task automatic wait_acc(input logic [15:0] a, input logic w);
    int k = 0;
    while (!(((w ? MEM_WR : MEM_RD) === 1'b1) && MEM_ADDR === a) && k < 300) begin
      @(negedge REF_CLK);
      k++;
    end
    chk("bus addr", a, MEM_ADDR);
  endtask
  initial begin
    #300000;
    n_fail++;
    final_report;
  end
  initial begin
    for (int r = 0; r < 12; r++) begin
      pg = '{16'h4034, rows[r].a, 16'h4035, rows[r].b, {rows[r].op, 4'h4, 1'b0, rows[r].bw,
        6'h05}, {8'h45, 1'b1, rows[r].bw, 6'h02}, 16'h0200, 16'h3FFF};
      boot(16'h1000);
      wait_acc(16'h1008, 1'b0);
      @(negedge REF_CLK);
      chk("next fetch", 16'h100A, MEM_ADDR);
      wait_acc(16'h0200, 1'b1);
      chk("byte strobe", {15'h0000, rows[r].bw}, {15'h0000, MEM_BYTE});
      @(negedge REF_CLK);
      chk("alu result", rows[r].e, mem_u.mem[16'h0100]);
      $display("test alu row %0d done", r);
    end
    for (int j = 0; j < 2; j++) begin
      pg = '{16'h4034, 16'h00A5, 16'h4035, 16'h00A5 + j[15:0], 16'h9405, 16'h2002,
        16'h3FFF, 16'h0000, 16'h3FFF};
      boot(16'h1000);
      wait_acc(16'h100A, 1'b0);
      wait_acc(j ? 16'h1010 : 16'h100C, 1'b0);
      $display("test jump case %0d done", j);
    end
    pg = '{16'h4031, 16'h0300, 16'h4038, 16'h2000, 16'h1288};
    boot(16'h1000);
    wait_acc(16'h02FE, 1'b1);
    chk("call push", 16'h100A, MEM_WDATA);
    wait_acc(16'h2000, 1'b0);
    $display("test call done");
    pg = '{16'h4031, 16'h0300, 16'hD232, 16'h3FFF};
    boot(16'h1000);
    wait_acc(16'h1006, 1'b0);
    repeat (3) @(negedge REF_CLK);
    IRQ_NUM = 5'h05;
    IRQ_REQ = 1'b1;
    wait_acc(16'hFFCA, 1'b0);
    chk("irq ack", 16'h0001, {15'h0000, IRQ_ACK});
    IRQ_REQ = 1'b0;
    wait_acc(16'h2000, 1'b0);
    chk("saved pc", 16'h1006, mem_u.mem[16'h017F]);
    wait_acc(16'h1006, 1'b0);
    $display("test interrupt done");
    // Status set to interrupts on plus cpu off, so the core parks in sleep
    pg = '{16'h4031, 16'h0300, 16'h4032, 16'h0018, 16'h3FFF};
    boot(16'h1000);
    repeat (12) @(negedge REF_CLK);
    chk("sleep entry", 16'h0001, {12'h000, SLEEP_MODE});
    IRQ_REQ = 1'b1;
    wait_acc(16'hFFCA, 1'b0);
    chk("awake", 16'h0000, {12'h000, SLEEP_MODE});
    IRQ_REQ = 1'b0;
    wait_acc(16'h02FC, 1'b0);
    repeat (3) @(negedge REF_CLK);
    chk("sleep restored", 16'h0001, {12'h000, SLEEP_MODE});
    chk("bus idle again", 16'h0000, {15'h0000, MEM_RD});
    $display("test wake from sleep done");
    pg = '{16'h3FFF};
    boot(16'hFFFF);
    repeat (4) @(negedge REF_CLK);
    chk("sleep mode", 16'h000F, {12'h000, SLEEP_MODE});
    chk("bus idle", 16'h0000, {15'h0000, MEM_RD});
    $display("test erased vector done");
    final_report;
  end
endmodule // tb_risc16_cpu_core_decode
`default_nettype wire
